// ==== logic/mss_top.sv ====
// Message sign supervisor: timing, blanking, brightness, tests, traps, AHB-Lite registers
//
// Summary of operation
// - Flash period programmable 0.5 s to 5 s in 0.1 s steps.
// - Alternation period programmable 0.5 s to 5 s in 0.1 s steps.
// - Flash period inside alternation always divides the phase on time.
// - Any character or group of characters may flash, static or alternating.
// - Over-temperature trap once per crossing; rearmed after dropping below limit.
// - Trap whenever mains supply fails.
// - Trap whenever mains power returns.
// - Trap whenever housing or cabinet door opens.
// - Status read returns address, brightness, errors, temperature, supply, origin, beacon, UPS.
// - Blank on power failure or controller failure.
// - Photocell indexes a 256-entry remotely writable brightness table.
// - Pixel test daily and on request, disturbing display under 0.5 s.
// - Pixel test tells dark pixels from stuck-lit pixels.
// - Each defective pixel logged with status, module, column, pixel, until LOG_DEPTH entries are held.
// - Blank above settable critical temperature and report at next poll.
// - Halve brightness once temperature reaches 130 F.
// - Blank the sign when message display time runs out.
// - Master mode only: blank after programmed minutes without communication.
// - Monitor LED supplies; report low voltage at next poll.
// - Fan test daily and on command; report failure at next poll.
// - Time-of-day clock removes message at scheduled time.
// - Clock keeps running through mains outages; display resumes after.
// - Two control modes, master and local.
`timescale 1ns/10ps
`default_nettype none
module mss_top
  import mss_pkg::*;
#(
  parameter int TENTH_CYCLES = TENTH_CYC,
  parameter int LOG_DEPTH = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sign sensors and pixel readback
  input wire mss_sense_t sense_i,
  input wire mss_pixrb_t pixrb_i,
  // Display control and traps
  output mss_disp_t disp_o,
  output logic [3:0] trap_pulse
);
  localparam int LW = $clog2(LOG_DEPTH);
  localparam int PIX_LIM = 5 * TENTH_CYCLES;

  typedef enum logic {PT_IDLE, PT_RUN} mss_pt_t;

  function automatic logic [7:0] clamp_per(input logic [7:0] v);
    if (v < PER_MIN) return PER_MIN;
    else if (v > PER_MAX) return PER_MAX;
    else return v;
  endfunction : clamp_per

  // Bus state
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic accept;
  logic rd_acc;
  logic [31:0] rd_word;
  // Registers
  logic [5:0] ctrl_r;
  logic [7:0] fl_set_r, al_set_r, safe_r, crit_r, brt_idx_r;
  logic [6:0] comto_r;
  logic [16:0] exp_tod_r, tod_r;
  logic exp_en_r, expired_r;
  logic [31:0] fmask_r;
  logic [EV_W-1:0] ev_r, ev_set;
  logic [7:0] tbl [256];
  // Timebase
  logic [31:0] pre_r;
  logic [3:0] tsub_r;
  logic [5:0] msub_r;
  logic [6:0] comm_min_r;
  logic tick, sec_tick, min_tick;
  // Display timing
  logic [7:0] al_cnt_r, fl_cnt_r, fl_eff;
  logic phase_r, blank_r, flash_on;
  logic [31:0] hide_r;
  logic [7:0] duty_r;
  // Monitors
  logic ot_armed_r, mains_d_r;
  logic [1:0] door_d_r;
  logic [3:0] trap_r;
  logic crit, comm_to, blank_nxt, daily;
  // Tests
  mss_pt_t pt_r;
  logic [7:0] pt_cnt_r, fan_cnt_r;
  logic fan_run_r;
  logic [31:0] pt_cyc_r;
  logic [31:0] plog [LOG_DEPTH];
  logic [LW-1:0] wp_r, rp_r;
  logic [LW:0] lcnt_r;
  logic push, pop;
  logic wr_ctrl;

  assign accept = hsel & hready & htrans[1];
  assign rd_acc = accept & ~hwrite;
  assign wr_ctrl = wr_pend_r && addr_r == A_CTRL;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= accept & hwrite;
      addr_r <= accept ? haddr[7:0] : addr_r;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      A_CTRL: rd_word = {26'h0, ctrl_r};
      A_FLASH: rd_word = {24'h0, fl_set_r};
      A_ALT: rd_word = {24'h0, al_set_r};
      A_TLIM: rd_word = {16'h0, crit_r, safe_r};
      A_COMTO: rd_word = {25'h0, comto_r};
      A_EXPIRE: rd_word = {exp_en_r, 14'h0, exp_tod_r};
      A_TOD: rd_word = {15'h0, tod_r};
      A_STATUS: rd_word = {lcnt_r[4:0] & 5'h1F, pt_r == PT_RUN, phase_r, blank_r,
                           sense_i.ups_ok, sense_i.beacon, ctrl_r[C_MASTER],
                           sense_i.mains_ok, sense_i.temp_f, duty_r, sense_i.ctrl_id};
      A_EVENTS: rd_word = {23'h0, ev_r};
      A_BRT_IDX: rd_word = {24'h0, brt_idx_r};
      A_PIXLOG: rd_word = (lcnt_r != '0) ? plog[rp_r] : 32'h0000_0000;
      A_FMASK: rd_word = fmask_r;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_r <= 32'h0000_0000;
    else if (rd_acc) hrdata_r <= rd_word;
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
      fl_set_r <= FLASH_RST;
      al_set_r <= ALT_RST;
      safe_r <= SAFE_RST;
      crit_r <= CRIT_RST;
      comto_r <= COMTO_RST;
      fmask_r <= 32'h0000_0000;
    end else if (wr_pend_r) begin
      unique case (addr_r)
        A_CTRL: ctrl_r <= hwdata[5:0] & 6'h27; // Test requests do not stick
        A_FLASH: fl_set_r <= clamp_per(hwdata[7:0]);
        A_ALT: al_set_r <= clamp_per(hwdata[7:0]);
        A_TLIM: {crit_r, safe_r} <= hwdata[15:0];
        A_COMTO: comto_r <= (hwdata[6:0] < COMTO_MIN) ? COMTO_MIN :
                            (hwdata[6:0] > COMTO_MAX) ? COMTO_MAX : hwdata[6:0];
        A_FMASK: fmask_r <= hwdata;
        default: ;
      endcase
    end
  end

  // Timebase: tenths, seconds, minutes and time of day
  assign tick = pre_r == 32'(TENTH_CYCLES - 1);
  assign sec_tick = tick && tsub_r == 4'(TENTHS_PER_SEC - 1);
  assign min_tick = sec_tick && msub_r == 6'(SEC_PER_MIN - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 32'h0000_0000;
      tsub_r <= 4'h0;
      msub_r <= 6'h00;
    end else begin
      pre_r <= tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
      if (tick) tsub_r <= sec_tick ? 4'h0 : tsub_r + 4'h1;
      if (sec_tick) msub_r <= min_tick ? 6'h00 : msub_r + 6'h01;
    end
  end

  // Backed-up clock: mains loss does not stop it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tod_r <= 17'h00000;
    else if (wr_pend_r && addr_r == A_TOD) tod_r <= hwdata[16:0];
    else if (sec_tick) tod_r <= (tod_r == 17'(SEC_PER_DAY - 1)) ? 17'h00000 : tod_r + 17'h00001;
  end

  // Scheduled removal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_en_r <= 1'b0;
      exp_tod_r <= 17'h00000;
      expired_r <= 1'b0;
    end else begin
      if (wr_pend_r && addr_r == A_EXPIRE) begin
        exp_en_r <= hwdata[31];
        exp_tod_r <= hwdata[16:0];
      end else if (exp_en_r && tod_r == exp_tod_r) begin
        exp_en_r <= 1'b0;
      end
      if (exp_en_r && tod_r == exp_tod_r) expired_r <= 1'b1;
      else if (wr_ctrl && hwdata[C_SHOW]) expired_r <= 1'b0;
    end
  end

  // Communication watchdog, minutes since last heartbeat
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) comm_min_r <= 7'h00;
    else if (wr_pend_r && addr_r == A_HEARTBEAT) comm_min_r <= 7'h00;
    else if (min_tick && comm_min_r != 7'h7F) comm_min_r <= comm_min_r + 7'h01;
  end
  assign comm_to = ctrl_r[C_MASTER] == MSS_MASTER && comm_min_r >= comto_r;

  // Flash and alternation
  // With alternation on, a flash period that does not divide the phase falls back to the phase length
  assign fl_eff = (ctrl_r[C_ALT] && (al_set_r % fl_set_r) != 8'h00) ? al_set_r : fl_set_r;
  assign flash_on = fl_cnt_r < {1'b0, fl_eff[7:1]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      al_cnt_r <= 8'h00;
      fl_cnt_r <= 8'h00;
      phase_r <= 1'b0;
    end else if (tick) begin
      if (al_cnt_r >= al_set_r - 8'h01) begin
        al_cnt_r <= 8'h00;
        phase_r <= ctrl_r[C_ALT] ? ~phase_r : 1'b0;
        fl_cnt_r <= 8'h00; // Flash restarts with each phase
      end else begin
        al_cnt_r <= al_cnt_r + 8'h01;
        fl_cnt_r <= (fl_cnt_r >= fl_eff - 8'h01) ? 8'h00 : fl_cnt_r + 8'h01;
      end
    end
  end

  // Blanking and brightness
  assign crit = sense_i.temp_f > crit_r;
  assign blank_nxt = !ctrl_r[C_SHOW] | ctrl_r[C_BLANK] | !sense_i.mains_ok | sense_i.ctrl_fail
                     | crit | expired_r | comm_to;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_r <= 1'b1;
      hide_r <= 32'h0000_0000;
      duty_r <= 8'h00;
    end else begin
      blank_r <= blank_nxt;
      hide_r <= fmask_r & {32{~flash_on}};
      duty_r <= (sense_i.temp_f >= HALF_TEMP_F) ? {1'b0, tbl[sense_i.photo][7:1]}
                                                 : tbl[sense_i.photo];
    end
  end

  // Brightness table, default is a linear ramp
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brt_idx_r <= 8'h00;
      for (int i = 0; i < 256; i++) tbl[i] <= 8'(i);
    end else if (wr_pend_r && addr_r == A_BRT_IDX) begin
      brt_idx_r <= hwdata[7:0];
    end else if (wr_pend_r && addr_r == A_BRT_DATA) begin
      tbl[brt_idx_r] <= hwdata[7:0];
      brt_idx_r <= brt_idx_r + 8'h01;
    end
  end

  // Trap sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ot_armed_r <= 1'b1;
      mains_d_r <= 1'b1;
      door_d_r <= 2'b00;
      trap_r <= 4'h0;
    end else begin
      if (sense_i.temp_f > safe_r) ot_armed_r <= 1'b0;
      else if (sense_i.temp_f < safe_r) ot_armed_r <= 1'b1;
      mains_d_r <= sense_i.mains_ok;
      door_d_r <= {sense_i.door_house, sense_i.door_cab};
      trap_r <= ev_set[3:0];
    end
  end
  assign trap_pulse = trap_r;

  assign daily = sec_tick && tod_r == DAILY_TEST_SEC;

  always_comb begin
    ev_set = '0;
    ev_set[EV_OT] = ot_armed_r && sense_i.temp_f > safe_r;
    ev_set[EV_MFAIL] = mains_d_r && !sense_i.mains_ok;
    ev_set[EV_MREST] = !mains_d_r && sense_i.mains_ok;
    ev_set[EV_DOOR] = |({sense_i.door_house, sense_i.door_cab} & ~door_d_r);
    ev_set[EV_CRIT] = crit;
    ev_set[EV_PSU] = sense_i.psu_low;
    ev_set[EV_FAN] = fan_run_r && tick && fan_cnt_r == 8'(FAN_TEST_TENTHS - 1)
                     && !sense_i.fan_ok;
    ev_set[EV_PIX] = push;
    ev_set[EV_COMM] = comm_to;
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev_r <= '0;
    else if (wr_pend_r && addr_r == A_EVENTS) ev_r <= (ev_r & ~hwdata[EV_W-1:0]) | ev_set;
    else ev_r <= ev_r | ev_set;
  end

  // Pixel test window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pt_r <= PT_IDLE;
      pt_cnt_r <= 8'h00;
    end else begin
      unique case (pt_r)
        PT_IDLE: if ((wr_ctrl && hwdata[C_PIXREQ]) || daily) begin
          pt_r <= PT_RUN;
          pt_cnt_r <= 8'h00;
        end
        PT_RUN: if (tick) begin
          if (pt_cnt_r == 8'(PIX_TEST_TENTHS - 1)) pt_r <= PT_IDLE;
          pt_cnt_r <= pt_cnt_r + 8'h01;
        end
      endcase
    end
  end

  // Defect log
  assign push = pt_r == PT_RUN && pixrb_i.valid && (pixrb_i.dark | pixrb_i.stuck)
                && lcnt_r != (LW+1)'(LOG_DEPTH);
  assign pop = rd_acc && haddr[7:0] == A_PIXLOG && lcnt_r != '0;

  always_ff @(posedge hclk) begin
    if (push) plog[wp_r] <= {pixrb_i.stuck, pixrb_i.dark, 6'h00, pixrb_i.module_no,
                             pixrb_i.column, pixrb_i.pixel};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r <= '0;
      rp_r <= '0;
      lcnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      lcnt_r <= lcnt_r + (LW+1)'(push) - (LW+1)'(pop);
    end
  end

  // Fan test
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_run_r <= 1'b0;
      fan_cnt_r <= 8'h00;
    end else if (!fan_run_r) begin
      fan_run_r <= (wr_ctrl && hwdata[C_FANREQ]) || daily;
      fan_cnt_r <= 8'h00;
    end else if (tick) begin
      fan_run_r <= fan_cnt_r != 8'(FAN_TEST_TENTHS - 1);
      fan_cnt_r <= fan_cnt_r + 8'h01;
    end
  end

  assign disp_o = '{blank: blank_r, phase: phase_r, char_hide: hide_r, duty: duty_r,
                    pix_test: pt_r == PT_RUN, fan_test: fan_run_r};

  // Checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pt_cyc_r <= 32'h0000_0000;
    else pt_cyc_r <= (pt_r == PT_RUN) ? pt_cyc_r + 32'h0000_0001 : 32'h0000_0000;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_pt_req;
    pt_r == PT_IDLE && wr_ctrl && hwdata[C_PIXREQ];
  endsequence
  sequence s_pt_on;
    ##1 pt_r == PT_RUN;
  endsequence

  property p_flash_range; fl_eff >= PER_MIN && fl_eff <= PER_MAX; endproperty
  a_flash_range: assert property (p_flash_range) else $error("flash period out of range");
  property p_alt_range; al_set_r >= PER_MIN && al_set_r <= PER_MAX; endproperty
  a_alt_range: assert property (p_alt_range) else $error("alt period out of range");
  property p_flash_div; ctrl_r[C_ALT] |-> (al_set_r % fl_eff) == 8'h00; endproperty
  a_flash_div: assert property (p_flash_div) else $error("flash not a divisor");
  property p_ot_once;
    trap_pulse[EV_OT] |-> !ot_armed_r ##1 !trap_pulse[EV_OT];
  endproperty
  a_ot_once: assert property (p_ot_once) else $error("repeated overtemp trap");
  property p_mains_fail; $fell(sense_i.mains_ok) |=> trap_pulse[EV_MFAIL] && blank_r; endproperty
  a_mains_fail: assert property (p_mains_fail) else $error("no mains fail trap");
  property p_mains_rest; $rose(sense_i.mains_ok) |=> trap_pulse[EV_MREST]; endproperty
  a_mains_rest: assert property (p_mains_rest) else $error("no restore trap");
  property p_door; $rose(sense_i.door_cab) |=> trap_pulse[EV_DOOR] && ev_r[EV_DOOR]; endproperty
  a_door: assert property (p_door) else $error("no door trap");
  property p_blank_fail; sense_i.ctrl_fail |=> blank_r && disp_o.blank; endproperty
  a_blank_fail: assert property (p_blank_fail) else $error("not blank on fault");
  property p_pix_start; s_pt_req |-> s_pt_on; endproperty
  a_pix_start: assert property (p_pix_start) else $error("pixel test not started");
  property p_pix_short; disp_o.pix_test |-> pt_cyc_r < 32'(PIX_LIM); endproperty
  a_pix_short: assert property (p_pix_short) else $error("pixel test too long");
  property p_half; sense_i.temp_f >= HALF_TEMP_F |=> duty_r <= 8'h7F; endproperty
  a_half: assert property (p_half) else $error("brightness not halved");
  property p_local_no_to; ctrl_r[C_MASTER] == MSS_LOCAL |-> !comm_to; endproperty
  a_local_no_to: assert property (p_local_no_to) else $error("timeout in local mode");
  property p_crit; crit |=> blank_r && ev_r[EV_CRIT]; endproperty
  a_crit: assert property (p_crit) else $error("critical temp not handled");
endmodule : mss_top
`default_nettype wire

// ==== logic/mss_pkg.sv ====
// Constants, register map and carrier types of the sign supervisor
package mss_pkg;
  localparam int CLK_NS = 10;
  localparam longint TENTH_NS = 100_000_000;
  localparam int TENTH_CYC = int'(TENTH_NS / CLK_NS);
  localparam int TENTHS_PER_SEC = 10;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_DAY = 86400;
  localparam logic [7:0] PER_MIN = 8'h05;
  localparam logic [7:0] PER_MAX = 8'h32;
  localparam int PIX_TEST_TENTHS = 4;
  localparam int FAN_TEST_TENTHS = 20;
  localparam logic [7:0] HALF_TEMP_F = 8'h82;
  localparam logic [16:0] DAILY_TEST_SEC = 17'h01C20;
  localparam logic [6:0] COMTO_MIN = 7'h01;
  localparam logic [6:0] COMTO_MAX = 7'h3C;
  // Word offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FLASH = 8'h04;
  localparam logic [7:0] A_ALT = 8'h08;
  localparam logic [7:0] A_TLIM = 8'h0C;
  localparam logic [7:0] A_COMTO = 8'h10;
  localparam logic [7:0] A_EXPIRE = 8'h14;
  localparam logic [7:0] A_TOD = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_EVENTS = 8'h20;
  localparam logic [7:0] A_BRT_IDX = 8'h24;
  localparam logic [7:0] A_BRT_DATA = 8'h28;
  localparam logic [7:0] A_PIXLOG = 8'h2C;
  localparam logic [7:0] A_FMASK = 8'h30;
  localparam logic [7:0] A_HEARTBEAT = 8'h34;
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] FLASH_RST = 8'h0A;
  localparam logic [7:0] ALT_RST = 8'h14;
  localparam logic [7:0] SAFE_RST = 8'h78;
  localparam logic [7:0] CRIT_RST = 8'h96;
  localparam logic [6:0] COMTO_RST = 7'h0A;
  // Control bits
  localparam int C_MASTER = 0;
  localparam int C_SHOW = 1;
  localparam int C_ALT = 2;
  localparam int C_PIXREQ = 3;
  localparam int C_FANREQ = 4;
  localparam int C_BLANK = 5;
  // Event bits
  localparam int EV_OT = 0;
  localparam int EV_MFAIL = 1;
  localparam int EV_MREST = 2;
  localparam int EV_DOOR = 3;
  localparam int EV_CRIT = 4;
  localparam int EV_PSU = 5;
  localparam int EV_FAN = 6;
  localparam int EV_PIX = 7;
  localparam int EV_COMM = 8;
  localparam int EV_W = 9;

  typedef enum logic {MSS_LOCAL, MSS_MASTER} mss_mode_t;

  typedef struct packed {
    logic [3:0] ctrl_id;
    logic [7:0] temp_f;
    logic [7:0] photo;
    logic mains_ok;
    logic door_house;
    logic door_cab;
    logic psu_low;
    logic fan_ok;
    logic ctrl_fail;
    logic ups_ok;
    logic beacon;
  } mss_sense_t;

  typedef struct packed {
    logic valid;
    logic dark;
    logic stuck;
    logic [7:0] module_no;
    logic [7:0] column;
    logic [7:0] pixel;
  } mss_pixrb_t;

  typedef struct packed {
    logic blank;
    logic phase;
    logic [31:0] char_hide;
    logic [7:0] duty;
    logic pix_test;
    logic fan_test;
  } mss_disp_t;
endpackage : mss_pkg

// ==== bench/mss_sign_model.sv ====
// Sign hardware model: pixel readback reports during a pixel test
`timescale 1ns/10ps
`default_nettype none
module mss_sign_model
  import mss_pkg::*;
#(
  parameter int GAP = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Display side
  input wire logic pix_test,
  output var mss_pixrb_t pixrb
);
  int cnt;
  logic [7:0] junk;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      junk <= 8'h00;
    end else begin
      cnt <= pix_test ? cnt + 1 : 0;
      junk <= junk + 8'h01;
    end
  end
  // Idle fields churn so stale values never look valid
  always_comb begin
    pixrb = '{1'b0, junk[0], junk[1], junk, ~junk, junk};
    if (pix_test && cnt == 2) pixrb = '{1'b1, 1'b1, 1'b0, 8'h03, 8'h07, 8'h09};
    if (pix_test && cnt == 2 + GAP) pixrb = '{1'b1, 1'b0, 1'b1, 8'h04, 8'h01, 8'h02};
  end
endmodule : mss_sign_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Register-level testbench of the sign supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); \
  end \
end
module tb_top;
  import mss_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hresp;
  logic phase_d = 1'b0;
  logic [31:0] hide_d = 32'h0;
  int phase_flips = 0;
  int hide_rises = 0;
  mss_sense_t sense = '{4'h5, 8'h64, 8'h10, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  mss_pixrb_t pixrb;
  mss_disp_t disp;
  logic [3:0] trap;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pt_len = 0;
  int tc [4] = '{0, 0, 0, 0};
  logic [7:0] vin [5] = '{8'h04, 8'h05, 8'h07, 8'h32, 8'h33};
  logic [7:0] vex [5] = '{8'h05, 8'h05, 8'h07, 8'h32, 8'h32};
  logic [7:0] tv [6] = '{8'h79, 8'h7D, 8'h78, 8'h79, 8'h77, 8'h79};
  int tx [6] = '{1, 1, 1, 1, 1, 2};
  logic [31:0] px [3] = '{32'h4003_0709, 32'h8004_0102, 32'h0};

  mss_top #(.TENTH_CYCLES(10), .LOG_DEPTH(16)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense_i(sense), .pixrb_i(pixrb),
    .disp_o(disp), .trap_pulse(trap)
  );
  mss_sign_model #(.GAP(5)) sign (
    .hclk(hclk), .hresetn(hresetn), .pix_test(disp.pix_test), .pixrb(pixrb)
  );

  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) if (trap[i] === 1'b1) tc[i]++;
    if (disp.pix_test === 1'b1) pt_len++;
    if (disp.phase !== phase_d) phase_flips++;
    if (disp.char_hide === 32'h5 && hide_d === 32'h0) hide_rises++;
    phase_d = disp.phase;
    hide_d = disp.char_hide;
  end
  // Whole run is about 16000 cycles, mostly the comm timeout wait
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step
  // Single word transfer; hold each phase until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    step(3);
    hresetn <= 1'b1;
    step(1);
    `CHK("blank_rst", 1'b1, disp.blank)
    ahb(0, A_FLASH, 0);
    `CHK("flash_rst", 32'h0A, rd)
    ahb(0, A_ALT, 0);
    `CHK("alt_rst", 32'h14, rd)
    `CHK("hresp_okay", 1'b0, hresp)
    for (int j = 0; j < 5; j++) begin
      ahb(1, A_FLASH, {24'h0, vin[j]});
      ahb(1, A_ALT, {24'h0, vin[4-j]});
      ahb(0, A_FLASH, 0);
      `CHK("flash", {24'h0, vex[j]}, rd)
      ahb(0, A_ALT, 0);
      `CHK("alt", {24'h0, vex[4-j]}, rd)
    end
    ahb(0, A_STATUS, 0);
    `CHK("status", 32'h01D6_4005, rd & 32'h01DF_F00F)
    ahb(0, 8'h3C, 0);
    `CHK("unmapped", 32'h0, rd)
    for (int k = 0; k < 6; k++) begin
      sense.temp_f <= tv[k];
      step(3);
      `CHK("ot_traps", tx[k], tc[0])
    end
    sense.temp_f <= 8'h64;
    ahb(1, A_BRT_IDX, 32'h10);
    ahb(1, A_BRT_DATA, 32'hAB);
    ahb(1, A_BRT_DATA, 32'hCD);
    step(4);
    `CHK("duty", 8'hAB, disp.duty)
    sense.photo <= 8'h11;
    step(4);
    `CHK("duty_next", 8'hCD, disp.duty)
    sense.temp_f <= 8'h81;
    step(4);
    `CHK("duty_129", 8'hCD, disp.duty)
    sense.temp_f <= 8'h82;
    step(4);
    `CHK("duty_half", 8'h66, disp.duty)
    ahb(1, A_CTRL, 32'h02);
    step(2);
    `CHK("shown", 1'b0, disp.blank)
    sense.mains_ok <= 1'b0;
    step(3);
    `CHK("mfail_trap", 1, tc[1])
    `CHK("mfail_blank", 1'b1, disp.blank)
    sense.mains_ok <= 1'b1;
    step(3);
    `CHK("mrest_trap", 1, tc[2])
    `CHK("mrest_blank", 1'b0, disp.blank)
    sense.ctrl_fail <= 1'b1;
    step(3);
    `CHK("cfail_blank", 1'b1, disp.blank)
    sense.ctrl_fail <= 1'b0;
    sense.door_cab <= 1'b1;
    step(3);
    sense.door_cab <= 1'b0;
    sense.door_house <= 1'b1;
    step(3);
    `CHK("door_traps", 2, tc[3])
    sense.door_house <= 1'b0;
    sense.temp_f <= 8'h97;
    step(3);
    `CHK("crit_blank", 1'b1, disp.blank)
    ahb(0, A_EVENTS, 0);
    `CHK("crit_event", 1'b1, rd[EV_CRIT])
    sense.temp_f <= 8'h96;
    step(3);
    `CHK("crit_equal", 1'b0, disp.blank)
    sense.temp_f <= 8'h64;
    sense.psu_low <= 1'b1;
    step(3);
    ahb(0, A_EVENTS, 0);
    `CHK("psu_event", 1'b1, rd[EV_PSU])
    sense.psu_low <= 1'b0;
    sense.fan_ok <= 1'b0;
    ahb(1, A_CTRL, 32'h12);
    step(1);
    `CHK("fan_window", 1'b1, disp.fan_test)
    step(229);
    `CHK("fan_done", 1'b0, disp.fan_test)
    ahb(0, A_EVENTS, 0);
    `CHK("fan_event", 1'b1, rd[EV_FAN])
    sense.fan_ok <= 1'b1;
    pt_len = 0;
    ahb(1, A_CTRL, 32'h0A);
    step(60);
    `CHK("pix_window", 1'b1, pt_len >= 30 && pt_len <= 40)
    for (int p = 0; p < 3; p++) begin
      ahb(0, A_PIXLOG, 0);
      `CHK("pix_log", px[p], rd)
    end
    ahb(1, A_TOD, 32'd100);
    ahb(1, A_EXPIRE, 32'h8000_0066);
    ahb(1, A_CTRL, 32'h02);
    step(2);
    `CHK("exp_shown", 1'b0, disp.blank)
    step(350);
    `CHK("exp_blank", 1'b1, disp.blank)
    ahb(0, A_EXPIRE, 0);
    `CHK("exp_enable", 1'b0, rd[31])
    pt_len = 0;
    ahb(1, A_TOD, {15'h0, DAILY_TEST_SEC});
    step(150);
    `CHK("daily_pix", 1'b1, pt_len >= 30 && pt_len <= 40)
    `CHK("daily_fan", 1'b1, disp.fan_test)
    // Second pass: period 8 does not divide 20, so flash falls back to the phase
    ahb(1, A_FMASK, 32'h5);
    ahb(1, A_FLASH, 32'd10);
    ahb(1, A_ALT, 32'd20);
    ahb(1, A_CTRL, 32'h06);
    for (int f = 0; f < 2; f++) begin
      step(250);
      phase_flips = 0;
      hide_rises = 0;
      step(800);
      `CHK("alt_flips", 1'b1, phase_flips >= 3 && phase_flips <= 5)
      `CHK("flash_rises", 1'b1, hide_rises >= 7 - 4 * f && hide_rises <= 9 - 4 * f)
      ahb(1, A_FLASH, 32'd8);
    end
    ahb(1, A_COMTO, 32'h1);
    ahb(1, A_CTRL, 32'h03);
    step(2);
    `CHK("comm_shown", 1'b0, disp.blank)
    step(13000);
    `CHK("comm_blank", 1'b1, disp.blank)
    ahb(0, A_EVENTS, 0);
    `CHK("comm_event", 1'b1, rd[EV_COMM])
    ahb(1, A_HEARTBEAT, 32'h0);
    step(2);
    `CHK("comm_resume", 1'b0, disp.blank)
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
